/* File: quad_dac_pkg.sv */
// ************************************************************
// frame, register and timing constants
// ************************************************************
package quad_dac_pkg;
   // frame layout
   localparam int          FRAME_BITS   = 24;
   localparam int          DATA_BITS    = 16;
   localparam int          ADDR_BITS    = 4;
   localparam int          CHANNELS     = 4;
   localparam int          RW_POS       = 23;
   localparam int          ADDR_MSB     = 19;
   localparam int          ADDR_LSB     = 16;
   localparam logic [4:0]  FRAME_LEN    = 5'h18;
   localparam logic [3:0]  READ_PAD     = 4'h0;
   localparam logic [23:0] SHIFT_RESET  = 24'h00_0000;

   // register addresses and address groups (upper two address bits)
   localparam logic [3:0]  ADDR_CMD     = 4'h0;
   localparam logic [3:0]  ADDR_MON     = 4'h1;
   localparam logic [1:0]  GRP_CTRL     = 2'h0;
   localparam logic [1:0]  GRP_DAC      = 2'h1;
   localparam logic [1:0]  GRP_ZERO     = 2'h2;
   localparam logic [1:0]  GRP_GAIN     = 2'h3;

   // command register fields
   localparam int          CMD_AB       = 15;
   localparam int          CMD_LD       = 14;
   localparam int          CMD_RST      = 13;
   localparam int          CMD_PDA      = 12;
   localparam int          CMD_PDB      = 11;
   localparam int          CMD_GPIO1    = 9;
   localparam int          CMD_GPIO0    = 8;
   localparam int          CMD_SERIAL_OUT_DISABLE     = 7;
   localparam int          CMD_GAIN_MSB = 5;
   localparam int          CMD_GAIN_LSB = 2;
   localparam logic [15:0] CMD_DEFAULT  = 16'h033C;
   localparam logic [15:0] CMD_KEEP     = 16'h9BFC;

   // monitor register fields
   localparam int          MON_CH_LSB   = 12;
   localparam int          MON_AIN      = 11;
   localparam logic [15:0] MON_KEEP     = 16'hF800;

   // calibration widths
   localparam int          ZERO_BITS    = 9;
   localparam int          GAIN_BITS    = 8;

   // timing
   localparam int          CLOCK_NS     = 5;
   localparam int          RECOVERY_NS  = 50_000;
   localparam int          RECOVERY_CYC = (RECOVERY_NS + CLOCK_NS - 1) / CLOCK_NS;
endpackage : quad_dac_pkg

/* File: quad_dac_serial_control_port.sv */
// Operation
// - 24-bit frames, MSB first, host clock
// - start at select fall, sample on falls
// - select high: ignore link, output released
// - select rise commits frame to register
// - frame: flag, reserved bits, address, data
// - short frame discarded, nothing updated
// - long frame keeps last 24 bits
// - output disable bit clear after reset
// - overflow bits out, driven on rise
// - read frame queues register for next transfer
// - read data uses write format
// - monitor routes at most one source
// - power-down keeps registers, port alive
// - clearing power-down starts 50us recovery
// - general pins open-drain, low on zero
// - general pin read returns pin level
// - general bits set to one at reset
// - load strobe or load bit updates latches
// - flag 23, zeros 22-20, address, data
// - only written channels reload on load
`timescale 1ns/1ps
module quad_dac_serial_control_port #(
   parameter int RECOVERY_CYCLES = quad_dac_pkg::RECOVERY_CYC
) (
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  wire logic               chipSelectN,
   input  wire logic               serialClock,
   input  wire logic               serialIn,
   output logic                    serialOut,
   output logic                    serialOutOe,
   input  wire logic               load_strobe_n,
   input  wire logic [1:0]         gpioIn,
   output logic      [1:0]         gpioOut,
   output logic      [1:0]         gpioOe,
   output logic                    group_a_powerdown,
   output logic                    group_b_powerdown,
   output logic                    groupAReady,
   output logic                    groupBReady,
   output logic      [4:0]         monitorSelect,
   output logic                    monitorEnable,
   output logic      [3:0][15:0]   dacLatch,
   output logic      [3:0][8:0]    zeroCode,
   output logic      [3:0][7:0]    gainCode,
   output logic      [3:0]         gainSelect,
   output logic                    abSelect
);
   localparam int RW = $clog2(RECOVERY_CYCLES + 1);
   localparam logic [RW-1:0] REC_LOAD = RW'(RECOVERY_CYCLES);

   // ************************************************************
   // synchronisers
   // ************************************************************
   logic [2:0] csSync_r;
   logic [2:0] sclkSync_r;
   logic [1:0] sdiSync_r;
   logic [2:0] ldSync_r;
   logic [1:0] gpioSync1_r;
   logic [1:0] gpioSync2_r;

   // pin inputs pass two flops; the third stage only feeds edge detection
   always_ff @(posedge clock)
   begin
      csSync_r    <= {csSync_r[1:0], chipSelectN};
      sclkSync_r  <= {sclkSync_r[1:0], serialClock};
      sdiSync_r   <= {sdiSync_r[0], serialIn};
      ldSync_r    <= {ldSync_r[1:0], load_strobe_n};
      gpioSync1_r <= gpioIn;
      gpioSync2_r <= gpioSync1_r;
   end

   logic csLow;
   logic csFall;
   logic csRise;
   logic sclkFall;
   logic sclkRise;
   logic ldLow;
   logic ldFall;

   // edges seen on the clean stages only
   assign csLow    = ~csSync_r[1];
   assign csFall   = csSync_r[2] & ~csSync_r[1];
   assign csRise   = ~csSync_r[2] & csSync_r[1];
   assign sclkFall = sclkSync_r[2] & ~sclkSync_r[1];
   assign sclkRise = ~sclkSync_r[2] & sclkSync_r[1];
   assign ldLow    = ~ldSync_r[1];
   assign ldFall   = ldSync_r[2] & ~ldSync_r[1];

   // ************************************************************
   // state
   // ************************************************************
   logic [23:0]   shift_r,    shift_nxt;
   logic [4:0]    count_r,    count_nxt;
   logic          readPend_r, readPend_nxt;
   logic [3:0]    readAddr_r, readAddr_nxt;
   logic [15:0]   cmd_r,      cmd_nxt;
   logic [15:0]   mon_r,      mon_nxt;
   logic [15:0]   dacIn_r     [4];
   logic [15:0]   dacIn_nxt   [4];
   logic [15:0]   latch_r     [4];
   logic [15:0]   latch_nxt   [4];
   logic [8:0]    zero_r      [4];
   logic [8:0]    zero_nxt    [4];
   logic [7:0]    gain_r      [4];
   logic [7:0]    gain_nxt    [4];
   logic [3:0]    dirty_r,    dirty_nxt;
   logic          sdo_r,      sdo_nxt;
   logic          sdoOe_r,    sdoOe_nxt;
   logic          softRst_r,  softRst_nxt;
   logic [RW-1:0] recA_r,     recA_nxt;
   logic [RW-1:0] recB_r,     recB_nxt;
   logic [4:0]    monSel_r,   monSel_nxt;
   logic [1:0]    gpioOe_r,   gpioOe_nxt;
   logic          loadEvt;
   logic          commit;

   // monitor source: lowest channel first, auxiliary input last
   function automatic logic [4:0] pickSource(input logic [15:0] mon);
      logic [4:0] sel;
      sel = 5'h00;
      for (int i = quad_dac_pkg::CHANNELS - 1; i >= 0; i--)
      begin
         if (mon[quad_dac_pkg::MON_CH_LSB + i])
            sel = 5'(1 << i);
      end
      if (sel == 5'h00 && mon[quad_dac_pkg::MON_AIN])
         sel = 5'h10;
      return sel;
   endfunction : pickSource

   // read-back value; general bits show the pin, self-clearing bits read zero
   // general bits read pin level
   function automatic logic [15:0] readValue(input logic [3:0] addr);
      logic [15:0] v;
      logic [1:0]  idx;
      v   = 16'h0000;
      idx = addr[1:0];
      if (addr == quad_dac_pkg::ADDR_CMD)
      begin
         v = cmd_r & quad_dac_pkg::CMD_KEEP;
         v[quad_dac_pkg::CMD_GPIO0] = gpioSync2_r[0];
         v[quad_dac_pkg::CMD_GPIO1] = gpioSync2_r[1];
      end
      else if (addr == quad_dac_pkg::ADDR_MON)
         v = mon_r;
      else if (addr[3:2] == quad_dac_pkg::GRP_DAC)
         v = dacIn_r[idx];
      else if (addr[3:2] == quad_dac_pkg::GRP_ZERO)
         v = {7'h00, zero_r[idx]};
      else if (addr[3:2] == quad_dac_pkg::GRP_GAIN)
         v = {8'h00, gain_r[idx]};
      return v;
   endfunction : readValue

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb
   begin
      logic [3:0]  addr;
      logic [15:0] data;
      logic [1:0]  idx;
      addr         = shift_r[quad_dac_pkg::ADDR_MSB:quad_dac_pkg::ADDR_LSB];
      data         = shift_r[quad_dac_pkg::DATA_BITS-1:0];
      idx          = addr[1:0];
      shift_nxt    = shift_r;
      count_nxt    = count_r;
      readPend_nxt = readPend_r;
      readAddr_nxt = readAddr_r;
      cmd_nxt      = cmd_r;
      mon_nxt      = mon_r;
      dacIn_nxt    = dacIn_r;
      latch_nxt    = latch_r;
      zero_nxt     = zero_r;
      gain_nxt     = gain_r;
      dirty_nxt    = dirty_r;
      sdo_nxt      = sdo_r;
      softRst_nxt  = 1'b0;
      loadEvt      = ldFall;
      // count saturates, shift keeps last 24
      if (sclkFall && csLow)
      begin
         shift_nxt = {shift_r[22:0], sdiSync_r[1]};
         if (count_r != quad_dac_pkg::FRAME_LEN)
            count_nxt = count_r + 5'h01;
      end
      // outgoing bit changes on the rise
      if (sclkRise && csLow)
         sdo_nxt = shift_r[23];
      // queued register loads at next frame start
      // same layout as a write frame
      if (csFall)
      begin
         count_nxt = 5'h00;
         if (readPend_r)
         begin
            shift_nxt    = {quad_dac_pkg::READ_PAD, readAddr_r, readValue(readAddr_r)};
            readPend_nxt = 1'b0;
         end
         sdo_nxt = shift_nxt[23];
      end
      commit = csRise && (count_r == quad_dac_pkg::FRAME_LEN);
      if (commit)
      begin
         if (shift_r[quad_dac_pkg::RW_POS])
         begin
            readPend_nxt = 1'b1;
            readAddr_nxt = addr;
         end
         else if (addr == quad_dac_pkg::ADDR_CMD)
         begin
            cmd_nxt     = data & quad_dac_pkg::CMD_KEEP;
            loadEvt     = loadEvt | data[quad_dac_pkg::CMD_LD];
            softRst_nxt = data[quad_dac_pkg::CMD_RST];
         end
         else if (addr == quad_dac_pkg::ADDR_MON)
            mon_nxt = data & quad_dac_pkg::MON_KEEP;
         else if (addr[3:2] == quad_dac_pkg::GRP_DAC)
         begin
            dacIn_nxt[idx] = data;
            // held-low strobe updates this channel at once
            if (ldLow)
               latch_nxt[idx] = data;
            else
               dirty_nxt[idx] = 1'b1;
         end
         else if (addr[3:2] == quad_dac_pkg::GRP_ZERO)
            zero_nxt[idx] = data[quad_dac_pkg::ZERO_BITS-1:0];
         else if (addr[3:2] == quad_dac_pkg::GRP_GAIN)
            gain_nxt[idx] = data[quad_dac_pkg::GAIN_BITS-1:0];
      end
      // strobe fall or load bit moves inputs
      // only dirty channels; a same-cycle write is included
      if (loadEvt)
      begin
         for (int c = 0; c < quad_dac_pkg::CHANNELS; c++)
         begin
            if (dirty_nxt[c])
               latch_nxt[c] = dacIn_nxt[c];
         end
         dirty_nxt = 4'h0;
      end
   end

   // output released whenever select is high
   // open-drain: enable when bit is zero
   // recovery timer starts on power-down clear
   always_comb
   begin
      sdoOe_nxt  = csLow & ~cmd_r[quad_dac_pkg::CMD_SERIAL_OUT_DISABLE];
      monSel_nxt = pickSource(mon_r);
      gpioOe_nxt = ~{cmd_r[quad_dac_pkg::CMD_GPIO1], cmd_r[quad_dac_pkg::CMD_GPIO0]};
      recA_nxt   = (recA_r != '0) ? recA_r - RW'(1) : recA_r;
      recB_nxt   = (recB_r != '0) ? recB_r - RW'(1) : recB_r;
      if (cmd_r[quad_dac_pkg::CMD_PDA] && !cmd_nxt[quad_dac_pkg::CMD_PDA])
         recA_nxt = REC_LOAD;
      if (cmd_r[quad_dac_pkg::CMD_PDB] && !cmd_nxt[quad_dac_pkg::CMD_PDB])
         recB_nxt = REC_LOAD;
   end

   // ************************************************************
   // registers
   // ************************************************************
   // software reset acts like the pin one cycle after its frame commits
   // general bits come up at one
   always_ff @(posedge clock)
   begin
      if (sys_rst || softRst_r)
      begin
         shift_r    <= quad_dac_pkg::SHIFT_RESET;
         count_r    <= 5'h00;
         readPend_r <= 1'b0;
         readAddr_r <= 4'h0;
         cmd_r      <= quad_dac_pkg::CMD_DEFAULT;
         mon_r      <= 16'h0000;
         dacIn_r    <= '{default: 16'h0000};
         latch_r    <= '{default: 16'h0000};
         zero_r     <= '{default: 9'h000};
         gain_r     <= '{default: 8'h00};
         dirty_r    <= 4'h0;
         sdo_r      <= 1'b0;
         sdoOe_r    <= 1'b0;
         softRst_r  <= 1'b0;
         recA_r     <= '0;
         recB_r     <= '0;
         monSel_r   <= 5'h00;
         gpioOe_r   <= 2'h0;
      end
      else
      begin
         shift_r    <= shift_nxt;
         count_r    <= count_nxt;
         readPend_r <= readPend_nxt;
         readAddr_r <= readAddr_nxt;
         cmd_r      <= cmd_nxt;
         mon_r      <= mon_nxt;
         dacIn_r    <= dacIn_nxt;
         latch_r    <= latch_nxt;
         zero_r     <= zero_nxt;
         gain_r     <= gain_nxt;
         dirty_r    <= dirty_nxt;
         sdo_r      <= sdo_nxt;
         sdoOe_r    <= sdoOe_nxt;
         softRst_r  <= softRst_nxt;
         recA_r     <= recA_nxt;
         recB_r     <= recB_nxt;
         monSel_r   <= monSel_nxt;
         gpioOe_r   <= gpioOe_nxt;
      end
   end

   // outputs come from flops except gpioOut, which is tied low; ready and monitor enable pass through a little decode
   // power-down touches only these outputs
   assign serialOut         = sdo_r;
   assign serialOutOe       = sdoOe_r;
   assign gpioOut           = 2'h0;           // open-drain pins only ever pull low
   assign gpioOe            = gpioOe_r;
   assign group_a_powerdown = cmd_r[quad_dac_pkg::CMD_PDA];
   assign group_b_powerdown = cmd_r[quad_dac_pkg::CMD_PDB];
   assign groupAReady       = ~cmd_r[quad_dac_pkg::CMD_PDA] & (recA_r == '0);
   assign groupBReady       = ~cmd_r[quad_dac_pkg::CMD_PDB] & (recB_r == '0);
   assign monitorSelect     = monSel_r;
   assign monitorEnable     = |monSel_r;
   assign gainSelect        = cmd_r[quad_dac_pkg::CMD_GAIN_MSB:quad_dac_pkg::CMD_GAIN_LSB];
   assign abSelect          = cmd_r[quad_dac_pkg::CMD_AB];
   always_comb
   begin
      for (int c = 0; c < quad_dac_pkg::CHANNELS; c++)
      begin
         dacLatch[c] = latch_r[c];
         zeroCode[c] = zero_r[c];
         gainCode[c] = gain_r[c];
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst || softRst_r);

   chk_sdo_release: assert property (!csLow |=> !serialOutOe)
      else $error("serial output driven while deselected");
   chk_short_frame: assert property (csRise && count_r != quad_dac_pkg::FRAME_LEN |=>
      $stable(cmd_r) && $stable(mon_r) && $stable(dacIn_r[0]) && !softRst_r)
      else $error("short frame changed a register");
   chk_commit_dac: assert property (commit && !shift_r[23] && shift_r[19:16] == 4'h4
      |=> dacIn_r[0] == $past(shift_r[15:0]))
      else $error("channel 0 input not written on commit");
   chk_shift_msb: assert property (sclkFall && csLow && !csFall
      |=> shift_r[0] == $past(sdiSync_r[1]) && shift_r[23:1] == $past(shift_r[22:0]))
      else $error("shift register did not take the sampled bit");
   chk_gpio_drive: assert property (##1 gpioOe == ~$past({cmd_r[9], cmd_r[8]}))
      else $error("general pin enable does not follow its bit");
   chk_mon_onehot: assert property ($onehot0(monitorSelect) && monitorEnable == |monitorSelect)
      else $error("more than one monitor source");
   chk_read_queue: assert property (commit && shift_r[23] |=> readPend_r ##0
      readAddr_r == $past(shift_r[19:16]))
      else $error("read frame did not queue its register");
   chk_load_clean: assert property (loadEvt && !dirty_r[1] && !(commit && shift_r[19:16] == 4'h5)
      |=> $stable(latch_r[1]))
      else $error("clean channel reloaded");
   chk_load_dirty: assert property (ldFall && dirty_r[2] && !commit
      |=> latch_r[2] == $past(dacIn_r[2]) && !dirty_r[2])
      else $error("dirty channel not loaded");
   chk_recovery: assert property ($fell(cmd_r[quad_dac_pkg::CMD_PDA]) |-> !groupAReady [*8])
      else $error("group a ready too soon");
endmodule : quad_dac_serial_control_port

/* File: spi_host_model.sv */
`timescale 1ns/1ps
// ************************************
// host side of the four-wire link
// ************************************
module spi_host_model (
   output logic      chipSelectN,
   output logic      serialClock,
   output logic      serialIn,
   input  wire logic serialOut
);
   // link idles deselected, clock parked low between frames
   initial
   begin
      chipSelectN = 1'b1;
      serialClock = 1'b0;
      serialIn    = 1'b0;
   end

   // msb-first burst
   // data changes on the rise so it is steady across the sampling fall;
   // reply bits are taken at each fall, where the device promises them
   task automatic xfer(input logic [31:0] frame, input int nbits, output logic [31:0] seen);
      seen = '0;
      chipSelectN = 1'b0;
      #100;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         #24;
         serialClock = 1'b1;
         serialIn    = frame[i];
         #24;
         seen = {seen[30:0], serialOut};
         serialClock = 1'b0;
      end
      // select rises only after the last fall
      #30;
      chipSelectN = 1'b1;
      serialIn = ~serialIn; // released line shows no stale level
      #20;
   endtask : xfer
endmodule : spi_host_model

/* File: quad_dac_serial_control_port_tb_top.sv */
`timescale 1ns/1ps
module quad_dac_serial_control_port_tb_top;
   logic             clock;
   logic             sys_rst;
   logic             chipSelectN;
   logic             serialClock;
   logic             serialIn;
   logic             serialOut;
   logic             serialOutOe;
   logic             load_strobe_n;
   logic [1:0]       gpioExt;
   logic [1:0]       gpioIn;
   logic [1:0]       gpioOut;
   logic [1:0]       gpioOe;
   logic             group_a_powerdown;
   logic             group_b_powerdown;
   logic             groupAReady;
   logic             groupBReady;
   logic [4:0]       monitorSelect;
   logic             monitorEnable;
   logic [3:0][15:0] dacLatch;
   logic [3:0][8:0]  zeroCode;
   logic [3:0][7:0]  gainCode;
   logic [3:0]       gainSelect;
   logic             abSelect;
   logic [31:0]      rx;
   int               errorCnt;
   int               testsRun;

   // ************************************
   // clock, pins and instances
   // ************************************
   always #2.5 clock = ~clock;

   // pulled-up pin: low when the device pulls it or the outside does
   assign gpioIn = gpioExt & ~gpioOe;

   quad_dac_serial_control_port #(.RECOVERY_CYCLES(20)) i_dut (
      .clock(clock), .sys_rst(sys_rst),
      .chipSelectN(chipSelectN), .serialClock(serialClock),
      .serialIn(serialIn), .serialOut(serialOut),
      .serialOutOe(serialOutOe), .load_strobe_n(load_strobe_n),
      .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .group_a_powerdown(group_a_powerdown),
      .group_b_powerdown(group_b_powerdown),
      .groupAReady(groupAReady), .groupBReady(groupBReady),
      .monitorSelect(monitorSelect), .monitorEnable(monitorEnable),
      .dacLatch(dacLatch), .zeroCode(zeroCode), .gainCode(gainCode),
      .gainSelect(gainSelect), .abSelect(abSelect)
   );

   spi_host_model i_host (
      .chipSelectN(chipSelectN), .serialClock(serialClock),
      .serialIn(serialIn), .serialOut(serialOut)
   );

   // ************************************
   // access and checking tasks
   // ************************************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("ERROR %s exp %h seen %h", what, exp, seen);
      end
   endtask : check

   // settle a few clocks so the commit after select rise has landed
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_host.xfer({8'h00, 1'b0, 3'b000, a, d}, 24, rx);
      repeat (4) @(posedge clock);
   endtask : wr

   // reserved bits and data set to ones: they must not matter
   task automatic rd(input logic [3:0] a);
      i_host.xfer({8'h00, 1'b1, 3'b111, a, 16'hFFFF}, 24, rx);
      repeat (4) @(posedge clock);
   endtask : rd

   task automatic pulse;
      @(posedge clock);
      load_strobe_n <= 1'b0;
      repeat (4) @(posedge clock);
      load_strobe_n <= 1'b1;
      repeat (4) @(posedge clock);
   endtask : pulse

   task automatic finalReport;
      $display("checks %0d errors %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finalReport

   // a hang costs one mismatch and ends the run
   initial
   begin
      #200_000;
      errorCnt++;
      finalReport();
   end

   // ************************************
   // test sequence
   // ************************************
   initial
   begin
      clock = 1'b0;
      sys_rst = 1'b1;
      load_strobe_n = 1'b1;
      gpioExt = 2'b11;
      errorCnt = 0;
      testsRun = 0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("sdo_oe", 24'(serialOutOe), 24'h00_0000);
      check("gpio_oe", 24'(gpioOe), 24'h00_0000);
      check("gpio_out", 24'(gpioOut), 24'h00_0000);
      check("gain", 24'(gainSelect), 24'h00_000F);
      check("mon_en", 24'(monitorEnable), 24'h00_0000);
      wr(4'h4, 16'hA5C3);
      wr(4'h5, 16'h1234);
      check("dac0", 24'(dacLatch[0]), 24'h00_0000);
      pulse();
      check("dac0", 24'(dacLatch[0]), 24'h00_A5C3);
      check("dac1", 24'(dacLatch[1]), 24'h00_1234);
      i_host.xfer({8'h00, 1'b0, 3'b000, 4'h6, 16'hBEEF}, 23, rx);
      pulse();
      check("dac2", 24'(dacLatch[2]), 24'h00_0000);
      // long frame keeps last bits, overflow comes out
      i_host.xfer({6'h00, 2'b10, 8'h06, 16'hC0DE}, 26, rx);
      check("ovfl", 24'(rx[1:0]), 24'h00_0002);
      pulse();
      check("dac2", 24'(dacLatch[2]), 24'h00_C0DE);
      gpioExt <= 2'b10;
      rd(4'h4);
      rd(4'h0);
      check("rd_dac0", rx[23:0], 24'h04_A5C3);
      wr(4'h2, 16'h0000);
      check("rd_cmd", rx[23:0], 24'h00_023C);
      wr(4'h0, 16'h113C);
      check("gpio_oe", 24'(gpioOe), 24'h00_0002);
      check("pd_a", 24'(group_a_powerdown), 24'h00_0001);
      check("rdy_a", 24'(groupAReady), 24'h00_0000);
      rd(4'h4);
      wr(4'h0, 16'h033C);
      check("rd_pd", rx[23:0], 24'h04_A5C3);
      check("rdy_a", 24'(groupAReady), 24'h00_0000);
      repeat (25) @(posedge clock);
      check("rdy_a", 24'(groupAReady), 24'h00_0001);
      // group b power-down and channel-pair select bit
      wr(4'h0, 16'h8B3C);
      check("ab_sel", 24'(abSelect), 24'h00_0001);
      check("pd_b", 24'(group_b_powerdown), 24'h00_0001);
      check("rdy_b", 24'(groupBReady), 24'h00_0000);
      wr(4'h0, 16'h033C);
      check("rdy_b", 24'(groupBReady), 24'h00_0000);
      repeat (25) @(posedge clock);
      check("rdy_b", 24'(groupBReady), 24'h00_0001);
      check("ab_sel", 24'(abSelect), 24'h00_0000);
      wr(4'h1, 16'h2800);
      check("mon", 24'(monitorSelect), 24'h00_0002);
      wr(4'h1, 16'h0800);
      check("mon", 24'(monitorSelect), 24'h00_0010);
      wr(4'h1, 16'h0000);
      check("mon_en", 24'(monitorEnable), 24'h00_0000);
      wr(4'h9, 16'hFFFF);
      wr(4'hE, 16'h0081);
      check("zero1", 24'(zeroCode[1]), 24'h00_01FF);
      check("zero0", 24'(zeroCode[0]), 24'h00_0000);
      check("gain2", 24'(gainCode[2]), 24'h00_0081);
      // strobe held low updates at commit
      @(posedge clock);
      load_strobe_n <= 1'b0;
      wr(4'h7, 16'h5A5A);
      load_strobe_n <= 1'b1;
      check("dac3", 24'(dacLatch[3]), 24'h00_5A5A);
      wr(4'h4, 16'h1111);
      wr(4'h0, 16'h433C);
      check("dac0", 24'(dacLatch[0]), 24'h00_1111);
      wr(4'h0, 16'h003C);
      check("gpio_oe", 24'(gpioOe), 24'h00_0003);
      wr(4'h0, 16'h233C);
      repeat (4) @(posedge clock);
      check("gpio_oe", 24'(gpioOe), 24'h00_0000);
      check("dac0", 24'(dacLatch[0]), 24'h00_0000);
      check("sdo_oe", 24'(serialOutOe), 24'h00_0000);
      finalReport();
   end
endmodule : quad_dac_serial_control_port_tb_top
